// ==== dv/asc_core_model.sv ====
`default_nettype none
// ----------------------------------------------------------------------------
// Converter core model on the far side of the sequencer
// ----------------------------------------------------------------------------
module asc_core_model
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Sequencer side.
   input wire asc_pkg::asc_core_out_s core_o,
   output var asc_pkg::asc_core_in_s core_i,
   // Latency and raw value chosen by the bench.
   input wire logic [3:0] lat,
   input wire logic [asc_pkg::RAW_W-1:0] raw
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0] cnt_ff; // Cycles left in the running conversion.

   // A conversion runs only after a start pulse; outside the done cycle the
   // data toggles so that a stale value is never mistaken for a result.
   always @(posedge mclk)
   begin
      core_i.done <= 1'b0;
      core_i.data <= ~core_i.data;
      if (rst)
      begin
         cnt_ff <= 4'h0;
         core_i.data <= 10'h2AA;
      end
      else if (core_o.start)
      begin
         cnt_ff <= lat;
      end
      else if (cnt_ff != 4'h0)
      begin
         cnt_ff <= cnt_ff - 4'h1;
         if (cnt_ff == 4'h1)
         begin
            core_i.done <= 1'b1;
            core_i.data <= raw;
         end
      end
   end
endmodule : asc_core_model
`default_nettype wire

// ==== dv/test_adc_sequencing_control.sv ====
`default_nettype none
// ----------------------------------------------------------------------------
// Self-checking bench of the sequencing control
// ----------------------------------------------------------------------------
module test_adc_sequencing_control;
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk = 1'b0; // System clock.
   logic rst = 1'b1; // Synchronous reset.
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic idle_mode = 1'b0;
   logic tmr = 1'b0; // Timer match pulse.
   logic pin = 1'b0; // External pin level.
   asc_pkg::asc_core_out_s core_o;
   asc_pkg::asc_core_in_s core_i;
   logic irq;
   logic [3:0] lat = 4'h1; // Model latency.
   logic [9:0] raw = 10'h0; // Next raw result.
   int seed = 84;
   int fails = 0;
   int n_compared = 0;
   logic [31:0] q; // Last read data.
   logic [15:0] ctl; // Control word in use.
   int len;
   int cnt;

   always #50 mclk = ~mclk;

   asc_top i_dut (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .idle_mode, .timer_three_match(tmr), .ext_int_zero_pin(pin),
      .core_o, .core_i, .irq);
   asc_core_model i_core (.mclk, .rst, .core_o, .core_i, .lat, .raw);

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("Compared %0d, mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // Counts one comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Classic single cycle; the request stands until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {16'h0, d};
      wb_sel_i <= 4'hF;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      if (wb_ack_o !== 1'b1)
      begin
         fails++;
         complete_run();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      // One idle cycle keeps back-to-back cycles apart.
      @(posedge mclk);
   endtask : wb

   // Reads a register and compares it.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 16'h0);
      chk(q, e);
   endtask : rd

   // Bounded wait: 0 acquire high, 1 acquire low, 2 interrupt high.
   task automatic wt(input int k);
      int n = 0;
      logic c;
      do
      begin
         @(posedge mclk);
         n++;
         c = (k == 0) ? core_o.acquire : (k == 1) ? !core_o.acquire : irq;
      end
      while (c !== 1'b1 && n < 300);
      if (c !== 1'b1)
      begin
         fails++;
         complete_run();
      end
   endtask : wt

   // Expected result: raw is offset binary, signed forms flip the top bit.
   function automatic logic [15:0] fmt_exp(input logic [1:0] f, input logic [9:0] r);
      logic [9:0] s;
      s = {~r[9], r[8:0]};
      case (f)
         2'h0: return {6'h00, r};
         2'h1: return {{6{s[9]}}, s};
         2'h2: return {r, 6'h00};
         default: return {s, 6'h00};
      endcase
   endfunction : fmt_exp

   // Main sequence.
   initial
   begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rd(asc_pkg::CTL_OFS, 32'h0);
      rd(asc_pkg::SMP_OFS, 32'h1);
      rd(8'h14, 32'h0);
      wb(1'b1, asc_pkg::MASK_OFS, 16'h1);
      // Switching on forces sample enable low, so it is set by a later write.
      wb(1'b1, asc_pkg::CTL_OFS, 16'h8000);
      // Software-ended sampling in every result format.
      for (int f = 0; f < 4; f++)
      begin
         raw <= 10'($random(seed));
         lat <= 4'(1 + {$random(seed)} % 8);
         ctl = 16'h8002 | 16'(f << 8);
         wb(1'b1, asc_pkg::CTL_OFS, ctl);
         wt(0);
         wb(1'b1, asc_pkg::CTL_OFS, ctl & 16'hFFFD);
         wt(2);
         rd(asc_pkg::RES_OFS, {16'h0, fmt_exp(2'(f), raw)});
         rd(asc_pkg::CTL_OFS, {16'h0, ctl & 16'hFFFD | 16'h1});
         rd(asc_pkg::STAT_OFS, 32'h3);
         chk({31'h0, irq}, 32'h0);
         $display("Format %0d done", f);
      end
      // Pin edge, timer match and counter with a random sample length.
      for (int i = 0; i < 3; i++)
      begin
         len = 1 + {$random(seed)} % 8;
         lat <= 4'(1 + {$random(seed)} % 8);
         wb(1'b1, asc_pkg::SMP_OFS, 16'(len));
         ctl = 16'h8002 | (i == 0 ? 16'h0020 : i == 1 ? 16'h0040 : 16'h00E0);
         wb(1'b1, asc_pkg::CTL_OFS, ctl);
         // The counter case is timed from the write edge, where acquire rises.
         if (i != 2)
            wt(0);
         cnt = 0;
         pin <= (i == 0);
         tmr <= (i == 1);
         while (core_o.acquire === 1'b1 && cnt < 40)
         begin
            @(posedge mclk);
            tmr <= 1'b0;
            cnt++;
         end
         pin <= 1'b0;
         if (cnt == 40)
            fails++;
         if (i == 2)
            chk(cnt, len);
         wt(2);
         rd(asc_pkg::STAT_OFS, 32'h3);
         rd(asc_pkg::CTL_OFS, {16'h0, ctl & 16'hFFFD | 16'h1});
         $display("Trigger %0d done", i);
      end
      // Automatic restart, then switching off.
      wb(1'b1, asc_pkg::SMP_OFS, 16'h8);
      // Idle without idle stop must not halt the sequencer.
      idle_mode <= 1'b1;
      wb(1'b1, asc_pkg::CTL_OFS, 16'h80E6);
      wt(2);
      wt(0);
      idle_mode <= 1'b0;
      rd(asc_pkg::CTL_OFS, 32'h80E7);
      wb(1'b1, asc_pkg::CTL_OFS, 16'h0000);
      rd(asc_pkg::RES_OFS, 32'h0);
      chk({31'h0, core_o.acquire}, 32'h0);
      wb(1'b0, asc_pkg::STAT_OFS, 16'h0);
      $display("Auto restart done");
      // A timer match during Idle with idle stop set is lost.
      wb(1'b1, asc_pkg::CTL_OFS, 16'hA040);
      wb(1'b1, asc_pkg::CTL_OFS, 16'hA042);
      wt(0);
      idle_mode <= 1'b1;
      @(posedge mclk);
      tmr <= 1'b1;
      @(posedge mclk);
      tmr <= 1'b0;
      repeat (4) @(posedge mclk);
      idle_mode <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({31'h0, core_o.acquire}, 32'h1);
      tmr <= 1'b1;
      @(posedge mclk);
      tmr <= 1'b0;
      wt(2);
      rd(asc_pkg::STAT_OFS, 32'h3);
      $display("Idle stop done");
      complete_run();
   end
endmodule : test_adc_sequencing_control
`default_nettype wire

// ==== rtl/asc_pin_sync.sv ====
`default_nettype none
// ----------------------------------------------------------------------------
// Two-stage synchroniser with rising edge detection
// ----------------------------------------------------------------------------
module asc_pin_sync
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Asynchronous pin and its synchronised edge.
   input wire logic pin_async,
   output logic rise
);

   logic meta_ff; // First stage, read only by the second stage.
   logic sync_ff; // Second stage, safe to use.
   logic dly_ff; // Delayed copy for the edge detector.
   logic nxt_meta;
   logic nxt_sync;
   logic nxt_dly;

   // Next values of the chain.
   always_comb
   begin
      nxt_meta = pin_async;
      nxt_sync = meta_ff;
      nxt_dly = sync_ff;
   end

   // Registers; reset clears the whole chain, so a pin already high at release gives one edge.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         dly_ff <= 1'b0;
      end
      else
      begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
         dly_ff <= nxt_dly;
      end
   end

   // One-cycle pulse on a rising edge.
   assign rise = sync_ff & ~dly_ff;

endmodule : asc_pin_sync
`default_nettype wire

// ==== rtl/asc_pkg.sv ====
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants and types of the converter sequencing control
// ----------------------------------------------------------------------------
package asc_pkg;

   // Width of the Wishbone byte address.
   localparam int ADR_W = 8;

   // Byte offsets of the registers.
   localparam logic [ADR_W-1:0] CTL_OFS = 8'h00;
   localparam logic [ADR_W-1:0] RES_OFS = 8'h04;
   localparam logic [ADR_W-1:0] STAT_OFS = 8'h08;
   localparam logic [ADR_W-1:0] MASK_OFS = 8'h0C;
   localparam logic [ADR_W-1:0] SMP_OFS = 8'h10;

   // Field positions of the control register.
   localparam int ON_BIT = 15;
   localparam int IDLE_BIT = 13;
   localparam int FMT_LSB = 8;
   localparam int TRIGGER_SOURCE_SELECT_LSB = 5;
   localparam int AUTO_SAMPLE_START_BIT = 2;
   localparam int SAMPLE_ENABLE_BIT = 1;
   localparam int DONE_BIT = 0;

   // Bits that software writes directly; the done bit is clear-only.
   localparam logic [15:0] CTL_WMASK = 16'hA3E6;
   localparam logic [15:0] CTL_RST = 16'h0000;

   // Trigger source codes.
   localparam logic [2:0] TRIGGER_SOURCE_SELECT_SW = 3'h0;
   localparam logic [2:0] TRIGGER_SOURCE_SELECT_EXTERNAL_INTERRUPT_ZERO_PIN = 3'h1;
   localparam logic [2:0] TRIGGER_SOURCE_SELECT_TMR = 3'h2;
   localparam logic [2:0] TRIGGER_SOURCE_SELECT_AUTO = 3'h7;

   // Result format codes.
   localparam logic [1:0] FMT_UINT = 2'h0;
   localparam logic [1:0] FMT_SINT = 2'h1;
   localparam logic [1:0] FMT_UFRAC = 2'h2;
   localparam logic [1:0] FMT_SFRAC = 2'h3;

   // Interrupt status layout: bit 0 conversion done, bit 1 sampling ended.
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_TRIG_BIT = 1;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

   // Auto-convert sample length in clock cycles.
   localparam int SMP_CNT_W = 5;
   localparam logic [SMP_CNT_W-1:0] SMP_CNT_RST = 5'h01;

   // Raw converter result width and formatted width.
   localparam int RAW_W = 10;
   localparam int RES_W = 16;

   // Control register layout.
   typedef struct packed {
      logic on;
      logic rsv14;
      logic idle_stop;
      logic [2:0] rsv12;
      logic [1:0] result_format;
      logic [2:0] trigger_source_select;
      logic [1:0] rsv4;
      logic auto_sample_start;
      logic sample_enable;
      logic done;
   } asc_ctl_s;

   // Signals toward the converter core.
   typedef struct packed {
      logic acquire;
      logic start;
   } asc_core_out_s;

   // Signals from the converter core.
   typedef struct packed {
      logic done;
      logic [RAW_W-1:0] data;
   } asc_core_in_s;

   // Sequencer states.
   typedef enum logic [1:0] {ASC_OFF, ASC_HOLD, ASC_SAMPLE, ASC_CONVERT} asc_state_e;

   // Register selection.
   typedef enum logic [2:0] {RS_CTL, RS_RES, RS_STAT, RS_MASK, RS_SMP, RS_NONE} asc_reg_e;

endpackage : asc_pkg
`default_nettype wire

// ==== rtl/asc_result_fmt.sv ====
`default_nettype none
// ----------------------------------------------------------------------------
// Result alignment and holding register
// ----------------------------------------------------------------------------
module asc_result_fmt
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Control.
   input wire logic clear,
   input wire logic load,
   input wire logic [1:0] fmt,
   // Data.
   input wire logic [asc_pkg::RAW_W-1:0] raw,
   output logic [asc_pkg::RES_W-1:0] res
);

   logic [asc_pkg::RES_W-1:0] res_ff; // Formatted result.
   logic [asc_pkg::RES_W-1:0] nxt_res;

   // Alignment; the raw code is offset binary, so the signed forms invert the top bit.
   always_comb
   begin
      nxt_res = res_ff;
      if (clear)
      begin
         nxt_res = '0;
      end
      else if (load)
      begin
         case (fmt)
            asc_pkg::FMT_SFRAC: nxt_res = {~raw[9], raw[8:0], 6'h00};
            asc_pkg::FMT_UFRAC: nxt_res = {raw, 6'h00};
            asc_pkg::FMT_SINT: nxt_res = {{6{~raw[9]}}, ~raw[9], raw[8:0]};
            default: nxt_res = {6'h00, raw};
         endcase
      end
   end

   // Result register.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         res_ff <= '0;
      end
      else
      begin
         res_ff <= nxt_res;
      end
   end

   assign res = res_ff;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   fmt_uint_a: assert property (!clear && load && fmt == asc_pkg::FMT_UINT |=> res == {6'h00, $past(raw)})
      else $error("integer result misaligned");
   fmt_sfrac_a: assert property (!clear && load && fmt == asc_pkg::FMT_SFRAC |=> res[5:0] == 6'h00
      && res[15] == !$past(raw[9]))
      else $error("signed fractional result wrong");
   res_clear_a: assert property (clear [*2] |-> res == '0)
      else $error("result kept while converter off");

endmodule : asc_result_fmt
`default_nettype wire

// ==== rtl/asc_top.sv ====
`default_nettype none
// ----------------------------------------------------------------------------
// Converter sequencing control with Wishbone register slave
// ----------------------------------------------------------------------------
// Behaviour
// - Converter runs only while converter_on is set.
// - Idle with idle_stop set halts the sequencer.
// - Result aligned by the two-bit format field.
// - Code 111: counter ends sampling, starts conversion.
// - Code 010: timer three match starts conversion.
// - Code 001: pin zero edge starts conversion.
// - Auto-sample sets sample_enable after each conversion.
// - Without auto-sample, software sets sample_enable.
// - Results are lost when converter is switched off.
module asc_top
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [asc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // System events.
   input wire logic idle_mode,
   input wire logic timer_three_match,
   input wire logic ext_int_zero_pin,
   // Converter core.
   output var asc_pkg::asc_core_out_s core_o,
   input wire asc_pkg::asc_core_in_s core_i,
   // Interrupt.
   output logic irq
);

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   asc_pkg::asc_ctl_s ctl_ff; // Control register.
   asc_pkg::asc_ctl_s nxt_ctl;
   asc_pkg::asc_state_e state_ff; // Sequencer state.
   asc_pkg::asc_state_e nxt_state;
   logic [asc_pkg::SMP_CNT_W-1:0] cnt_ff; // Cycles spent sampling.
   logic [asc_pkg::SMP_CNT_W-1:0] nxt_cnt;
   logic [asc_pkg::SMP_CNT_W-1:0] smp_ff; // Auto-convert sample length.
   logic [asc_pkg::SMP_CNT_W-1:0] nxt_smp;
   logic [asc_pkg::SMP_CNT_W-1:0] lim_m1; // Last counter value of a sample.
   logic [asc_pkg::IRQ_W-1:0] stat_ff; // Sticky event flags.
   logic [asc_pkg::IRQ_W-1:0] nxt_stat;
   logic [asc_pkg::IRQ_W-1:0] mask_ff; // Interrupt enables.
   logic [asc_pkg::IRQ_W-1:0] nxt_mask;
   logic start_ff; // Conversion start pulse.
   logic nxt_start;
   logic acq_ff; // Sample-and-hold acquire level.
   logic ack_ff; // Bus acknowledge.
   logic nxt_ack;
   logic [31:0] dat_ff; // Bus read data.
   logic [31:0] nxt_dat;
   logic [15:0] wr_val; // Control value merged with a write.
   logic [15:0] lane; // Byte lanes of a control write.
   logic wr_stb; // Write taking effect this edge.
   logic sw_sample_enable; // Sample enable as software leaves it this edge.
   logic rd_stb; // Read completing this edge.
   logic active; // Sequencer allowed to advance.
   logic trig; // Selected trigger fired.
   logic ev_trig; // Sampling ended this cycle.
   logic ev_done; // Conversion finished this cycle.
   logic res_load; // Capture the core's result.
   logic ext_rise; // Synchronised pin edge.
   logic [asc_pkg::RES_W-1:0] res; // Formatted result.

   // Register decode, shared by the write and read paths.
   function automatic asc_pkg::asc_reg_e reg_decode(input logic [asc_pkg::ADR_W-1:0] adr);
      case ({adr[asc_pkg::ADR_W-1:2], 2'b00})
         asc_pkg::CTL_OFS: reg_decode = asc_pkg::RS_CTL;
         asc_pkg::RES_OFS: reg_decode = asc_pkg::RS_RES;
         asc_pkg::STAT_OFS: reg_decode = asc_pkg::RS_STAT;
         asc_pkg::MASK_OFS: reg_decode = asc_pkg::RS_MASK;
         asc_pkg::SMP_OFS: reg_decode = asc_pkg::RS_SMP;
         default: reg_decode = asc_pkg::RS_NONE;
      endcase
   endfunction : reg_decode

   // -------------------------------------------------------------------------
   // Submodules
   // -------------------------------------------------------------------------
   // The pin is asynchronous, so it passes two flip-flops before the edge test.
   asc_pin_sync u_sync
   (
      .mclk(mclk),
      .rst(rst),
      .pin_async(ext_int_zero_pin),
      .rise(ext_rise)
   );

   // Result alignment; cleared while the converter is off.
   asc_result_fmt u_fmt
   (
      .mclk(mclk),
      .rst(rst),
      .clear(!ctl_ff.on),
      .load(res_load),
      .fmt(ctl_ff.result_format),
      .raw(core_i.data),
      .res(res)
   );

   // -------------------------------------------------------------------------
   // Sequencer and registers
   // -------------------------------------------------------------------------
   // A write lands at the edge where the master sees ack.
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
   assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ack_ff;
   assign active = ctl_ff.on & ~(idle_mode & ctl_ff.idle_stop);
   assign lim_m1 = (smp_ff == '0) ? '0 : smp_ff - 1'b1;
   assign lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // A write may only clear done; writing one leaves it alone.
   always_comb
   begin
      wr_val = (16'(ctl_ff) & ~asc_pkg::CTL_WMASK) | (wb_dat_i[15:0] & asc_pkg::CTL_WMASK);
      wr_val[asc_pkg::DONE_BIT] = ctl_ff.done & wb_dat_i[asc_pkg::DONE_BIT];
      // Taken from ctl_ff and the bus only, so the software trigger forms no loop through nxt_ctl.
      sw_sample_enable = ctl_ff.sample_enable;
      if (wr_stb && wb_sel_i[0] && reg_decode(wb_adr_i) == asc_pkg::RS_CTL)
      begin
         sw_sample_enable = wb_dat_i[asc_pkg::SAMPLE_ENABLE_BIT];
      end
   end

   // Trigger selection; reserved codes never fire.
   always_comb
   begin
      case (ctl_ff.trigger_source_select)
         asc_pkg::TRIGGER_SOURCE_SELECT_SW: trig = !sw_sample_enable;
         asc_pkg::TRIGGER_SOURCE_SELECT_EXTERNAL_INTERRUPT_ZERO_PIN: trig = ext_rise;
         asc_pkg::TRIGGER_SOURCE_SELECT_TMR: trig = timer_three_match;
         asc_pkg::TRIGGER_SOURCE_SELECT_AUTO: trig = (cnt_ff >= lim_m1);
         default: trig = 1'b0;
      endcase
   end

   // Next values: software writes first, hardware after, so hardware sets win.
   always_comb
   begin
      nxt_ctl = ctl_ff;
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_smp = smp_ff;
      nxt_mask = mask_ff;
      nxt_start = 1'b0;
      ev_trig = 1'b0;
      ev_done = 1'b0;
      res_load = 1'b0;
      // Software side.
      if (wr_stb && reg_decode(wb_adr_i) == asc_pkg::RS_CTL)
      begin
         nxt_ctl = asc_pkg::asc_ctl_s'((16'(ctl_ff) & ~lane) | (wr_val & lane));
      end
      if (wr_stb && wb_sel_i[0] && reg_decode(wb_adr_i) == asc_pkg::RS_SMP)
      begin
         nxt_smp = wb_dat_i[asc_pkg::SMP_CNT_W-1:0];
      end
      if (wr_stb && wb_sel_i[0] && reg_decode(wb_adr_i) == asc_pkg::RS_MASK)
      begin
         nxt_mask = wb_dat_i[asc_pkg::IRQ_W-1:0];
      end
      // Hardware side.
      if (!ctl_ff.on)
      begin
         // Off: nothing samples or converts.
         nxt_state = asc_pkg::ASC_OFF;
         nxt_ctl.sample_enable = 1'b0;
         nxt_cnt = '0;
      end
      else if (active)
      begin
         case (state_ff)
            asc_pkg::ASC_OFF:
            begin
               nxt_state = asc_pkg::ASC_HOLD;
            end
            asc_pkg::ASC_HOLD:
            begin
               // Only software starts a sample from hold.
               if (nxt_ctl.sample_enable)
               begin
                  nxt_state = asc_pkg::ASC_SAMPLE;
                  nxt_ctl.done = 1'b0;
                  nxt_cnt = '0;
               end
            end
            asc_pkg::ASC_SAMPLE:
            begin
               if (cnt_ff != '1)
               begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
               if (trig)
               begin
                  // Trigger ends the sample and launches the conversion.
                  nxt_ctl.sample_enable = 1'b0;
                  nxt_start = 1'b1;
                  nxt_state = asc_pkg::ASC_CONVERT;
                  ev_trig = 1'b1;
               end
               else if (!nxt_ctl.sample_enable)
               begin
                  // Software abort under a hardware trigger: back to hold.
                  nxt_state = asc_pkg::ASC_HOLD;
               end
            end
            asc_pkg::ASC_CONVERT:
            begin
               if (core_i.done)
               begin
                  nxt_ctl.done = 1'b1;
                  ev_done = 1'b1;
                  res_load = 1'b1;
                  if (ctl_ff.auto_sample_start)
                  begin
                     nxt_ctl.sample_enable = 1'b1;
                     nxt_state = asc_pkg::ASC_SAMPLE;
                     nxt_cnt = '0;
                  end
                  else
                  begin
                     nxt_state = asc_pkg::ASC_HOLD;
                  end
               end
            end
            default:
            begin
               nxt_state = asc_pkg::ASC_OFF;
            end
         endcase
      end
      // Clear only what the read reported, so an event during the read survives.
      nxt_stat = stat_ff & ~(rd_stb && reg_decode(wb_adr_i) == asc_pkg::RS_STAT ?
         dat_ff[asc_pkg::IRQ_W-1:0] : asc_pkg::IRQ_RST);
      nxt_stat[asc_pkg::IRQ_DONE_BIT] = nxt_stat[asc_pkg::IRQ_DONE_BIT] | ev_done;
      nxt_stat[asc_pkg::IRQ_TRIG_BIT] = nxt_stat[asc_pkg::IRQ_TRIG_BIT] | ev_trig;
   end

   // Registers of the sequencer group.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ctl_ff <= asc_pkg::asc_ctl_s'(asc_pkg::CTL_RST);
         state_ff <= asc_pkg::ASC_OFF;
         cnt_ff <= '0;
         smp_ff <= asc_pkg::SMP_CNT_RST;
         mask_ff <= asc_pkg::IRQ_RST;
         stat_ff <= asc_pkg::IRQ_RST;
         start_ff <= 1'b0;
         acq_ff <= 1'b0;
      end
      else
      begin
         ctl_ff <= nxt_ctl;
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         smp_ff <= nxt_smp;
         mask_ff <= nxt_mask;
         stat_ff <= nxt_stat;
         start_ff <= nxt_start;
         acq_ff <= (nxt_state == asc_pkg::ASC_SAMPLE);
      end
   end

   // -------------------------------------------------------------------------
   // Bus answer
   // -------------------------------------------------------------------------
   // Ack comes one cycle after the request and drops the cycle after.
   always_comb
   begin
      nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
      nxt_dat = 32'h00000000;
      if (nxt_ack && !wb_we_i)
      begin
         case (reg_decode(wb_adr_i))
            asc_pkg::RS_CTL: nxt_dat = 32'(ctl_ff);
            asc_pkg::RS_RES: nxt_dat = 32'(res);
            asc_pkg::RS_STAT: nxt_dat = 32'(stat_ff);
            asc_pkg::RS_MASK: nxt_dat = 32'(mask_ff);
            asc_pkg::RS_SMP: nxt_dat = 32'(smp_ff);
            default: nxt_dat = 32'h00000000;
         endcase
      end
   end

   // Registers of the bus group.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h00000000;
      end
      else
      begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;
   assign core_o = '{acquire: acq_ff, start: start_ff};
   assign irq = |(stat_ff & mask_ff);

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_sampling;
      state_ff == asc_pkg::ASC_SAMPLE && active;
   endsequence

   sequence s_conv_end;
      state_ff == asc_pkg::ASC_CONVERT && active && core_i.done;
   endsequence

   sequence s_launched;
      start_ff && state_ff == asc_pkg::ASC_CONVERT && !ctl_ff.sample_enable;
   endsequence

   off_gate_a: assert property (!ctl_ff.on |=> state_ff == asc_pkg::ASC_OFF && !start_ff && !core_o.acquire)
      else $error("converter active while off");
   idle_halt_a: assert property (ctl_ff.on && idle_mode && ctl_ff.idle_stop |=> $stable(state_ff) && !start_ff)
      else $error("sequencer moved while halted in idle");
   auto_end_a: assert property (s_sampling ##0 ctl_ff.trigger_source_select == asc_pkg::TRIGGER_SOURCE_SELECT_AUTO
      && cnt_ff >= lim_m1 |=> s_launched)
      else $error("auto-convert counter did not start conversion");
   timer_end_a: assert property (s_sampling ##0 ctl_ff.trigger_source_select == asc_pkg::TRIGGER_SOURCE_SELECT_TMR
      && timer_three_match |=> s_launched)
      else $error("timer match did not start conversion");
   pin_end_a: assert property (s_sampling ##0 ctl_ff.trigger_source_select == asc_pkg::TRIGGER_SOURCE_SELECT_EXTERNAL_INTERRUPT_ZERO_PIN
      && ext_rise |=> s_launched)
      else $error("pin edge did not start conversion");
   auto_restart_a: assert property (s_conv_end ##0 ctl_ff.auto_sample_start |=>
      state_ff == asc_pkg::ASC_SAMPLE && ctl_ff.sample_enable && core_o.acquire)
      else $error("sampling not restarted after conversion");
   manual_hold_a: assert property (s_conv_end ##0 !ctl_ff.auto_sample_start |=> state_ff == asc_pkg::ASC_HOLD)
      else $error("sampling restarted without software");
   sw_end_a: assert property (s_sampling ##0 ctl_ff.trigger_source_select == asc_pkg::TRIGGER_SOURCE_SELECT_SW
      && !nxt_ctl.sample_enable |=> s_launched)
      else $error("software clear did not start conversion");
   done_flag_a: assert property (s_conv_end |=> ctl_ff.done && stat_ff[asc_pkg::IRQ_DONE_BIT])
      else $error("done not flagged after conversion");
   done_clr_a: assert property (state_ff == asc_pkg::ASC_HOLD && active ##1 state_ff == asc_pkg::ASC_SAMPLE
      |-> !ctl_ff.done)
      else $error("done not cleared at sampling start");
   bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !ack_ff |=> ack_ff ##1 !ack_ff)
      else $error("bus answer not one cycle");

endmodule : asc_top
`default_nettype wire
